// ==== hw/access_pkg.sv ====
// constants for the adaptive priority net access scheduler
package access_pkg;
  localparam int CLK_MHZ = 250;
  // precedence encodings on the link and in the local queue
  localparam logic [1:0] PREC_URGENT = 2'h0;
  localparam logic [1:0] PREC_PRIORITY = 2'h1;
  localparam logic [1:0] PREC_ROUTINE = 2'h2;
  // upper bound on the start-up delay, in milliseconds
  localparam int MAX_START_MS = 20000;
  localparam longint MAX_START_CYC = longint'(MAX_START_MS) * 1000 * CLK_MHZ;
  // stations that a worst case acknowledged message is sent to
  localparam int WORST_ADDRESSEES = 16;
  localparam logic [5:0] OPP_RESET = 6'h00;
  localparam logic [7:0] STATION_RESET = 8'h00;
endpackage : access_pkg

// ==== hw/adaptive_priority_net_access.sv ====
// access scheduler for one station on a shared data radio net
// Summary of operation
// (R1) no urgent: wait until opportunity NS+1
// (R2) routine only: wait until opportunity 2NS+1
// (R3) from 2NS+1 any queued traffic may send
// (R4) priority mode: first slot for urgent
// (R5) after revert, lead station goes first
// (R6) stay urgent until all stations offered
// (R7) routine mode: first slot urgent or priority
// (R8) transmit precedence 0, 1 or 2
// (R9) load network precedence from received header
// (R10) local queue precedence 0, 1 or 2
// (R11) missed term means wait for next
// (R12) start-up delay from turnaround and station count
// (R13) start-up delay capped at 20 seconds
// (R14) turnaround assumes acknowledged 16-station message
// (R15) voice variant adds step to lead number
// (R16) data variant increments lead number
// (R17) count opportunities since last transmission end
`timescale 1ns/10ps
module adaptive_priority_net_access
  import access_pkg::*;
#(
  parameter int STATION_W = 8,
  parameter int OPP_W = 6,
  parameter logic [STATION_W-1:0] FIRST_STATION_STEP = 8'h01,
  // cycle counts of one access period's pieces, from which the start-up delay is built
  parameter int TURNAROUND_BASE_CYC = 250000,
  parameter int TURNAROUND_PER_DEST_CYC = 25000,
  parameter int BUSY_SENSE_CYC = 5000,
  parameter int TERMINAL_TURN_CYC = 5000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [STATION_W-1:0] net_station_total,
  input wire logic [STATION_W-1:0] own_station,
  input wire logic voice_data_mode,
  input wire logic link_up,
  input wire logic urgent_queued,
  input wire logic priority_queued,
  input wire logic routine_queued,
  input wire logic rx_end,
  input wire logic [1:0] rx_link_precedence,
  input wire logic [STATION_W-1:0] rx_lead_station,
  input wire logic opportunity_tick,
  input wire logic tx_start,
  output logic tx_grant,
  output logic [1:0] tx_link_precedence,
  output logic [STATION_W-1:0] tx_lead_station,
  output logic urgent_mode,
  output logic startup_wait
);
  typedef enum logic [1:0] {ST_INIT, ST_IDLE} sched_e;
  sched_e state_ff, nxt_state;
  logic [OPP_W-1:0] opp_ff;
  logic [1:0] np_ff;
  logic [STATION_W-1:0] lead_ff;
  logic [STATION_W:0] offered_ff;
  logic urgent_ff;
  logic [35:0] start_cnt_ff;
  logic [STATION_W-1:0] own_slot_ff;
  logic [1:0] tx_prec_ff;
  logic [STATION_W-1:0] tx_lead_ff;
  logic grant_ff;

  //////////////////////////////////////////////////////////////////////////
  // (R10) local queue precedence
  wire logic [1:0] queue_prec = urgent_queued ? PREC_URGENT :
                                priority_queued ? PREC_PRIORITY : PREC_ROUTINE;
  wire logic any_queued = urgent_queued | priority_queued | routine_queued;
  wire logic [OPP_W-1:0] ns_w = OPP_W'(net_station_total);
  wire logic [OPP_W-1:0] thr_priority = ns_w + OPP_W'(1);
  wire logic [OPP_W-1:0] thr_routine = OPP_W'({ns_w, 1'b0}) + OPP_W'(1);

  // (R12) start-up delay: turnaround + (3NS+1) busy sense + 3NS turnarounds
  // (R14) worst case turnaround covers 16 acknowledging addressees
  wire logic [35:0] ns3 = 36'(net_station_total) * 36'h3;
  wire logic [35:0] worst_tp = 36'(TURNAROUND_BASE_CYC)
                             + 36'(WORST_ADDRESSEES) * 36'(TURNAROUND_PER_DEST_CYC);
  wire logic [35:0] initial_access_delay_raw = worst_tp + (ns3 + 36'h1) * 36'(BUSY_SENSE_CYC)
                             + ns3 * 36'(TERMINAL_TURN_CYC);
  // (R13) cap at twenty seconds
  wire logic [35:0] initial_access_delay_cyc = (initial_access_delay_raw > 36'(MAX_START_CYC)) ? 36'(MAX_START_CYC)
                                                                : initial_access_delay_raw;

  // (R4) (R7) reserved first slot after each transmission end
  wire logic first_slot = (opp_ff == OPP_RESET);
  wire logic reserved_ok = urgent_ff ? 1'b0 :
                           (np_ff == PREC_PRIORITY) ? urgent_queued :
                           (urgent_queued | priority_queued);
  // (R5) lead station gets the first regular slot in urgent mode
  wire logic lead_slot = urgent_ff && (opp_ff == OPP_W'(1)) && (own_station == lead_ff);
  // (R11) own computed slot, rolling to the next term when missed
  wire logic own_term = (opp_ff >= OPP_W'(1)) &&
                        (OPP_W'(own_slot_ff) == opp_ff);
  // (R1) (R2) (R3) precedence thresholds
  wire logic thr_ok = (queue_prec == PREC_URGENT) ? 1'b1 :
                      (queue_prec == PREC_PRIORITY) ? (opp_ff >= thr_priority) :
                      (opp_ff >= thr_routine);
  wire logic may_send = (state_ff == ST_IDLE) && any_queued &&
                        ((first_slot && reserved_ok) || lead_slot ||
                         (!first_slot && own_term && thr_ok));

  // delay counts only once the station can send and receive
  wire logic start_counting = (state_ff == ST_INIT) && link_up;
  wire logic start_done = link_up && (start_cnt_ff >= initial_access_delay_cyc);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_INIT: begin
        if (start_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: nxt_state = ST_IDLE;
      default: nxt_state = ST_INIT;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_INIT;
      start_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (start_counting) begin
        start_cnt_ff <= start_cnt_ff + 36'h1;
      end
    end
  end

  // (R17) opportunity counter cleared by each transmission end
  // saturates so a long quiet net never wraps back into the reserved slot
  wire logic opp_step = opportunity_tick && (opp_ff != '1);

  always_ff @(posedge clk) begin
    if (rst) begin
      opp_ff <= OPP_RESET;
    end else if (rx_end) begin
      opp_ff <= OPP_RESET;
    end else if (opp_step) begin
      opp_ff <= opp_ff + OPP_W'(1);
    end
  end

  // (R9) network precedence and lead number from last header
  always_ff @(posedge clk) begin
    if (rst) begin
      np_ff <= PREC_ROUTINE;
      lead_ff <= STATION_RESET;
    end else if (rx_end) begin
      np_ff <= rx_link_precedence;
      lead_ff <= rx_lead_station;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // (R6) urgent mode held until every station offered a slot
  wire logic urgent_enter = rx_end && (rx_link_precedence == PREC_URGENT) && !urgent_ff;
  wire logic offer_tick = urgent_ff && opportunity_tick && !first_slot;
  wire logic [STATION_W:0] nxt_offered = offered_ff + (STATION_W+1)'(1);
  // the reserved slot is not counted, only slots a station could take
  wire logic all_offered = (nxt_offered >= {1'b0, net_station_total});

  always_ff @(posedge clk) begin
    if (rst) begin
      urgent_ff <= 1'b0;
      offered_ff <= '0;
    end else if (urgent_enter) begin
      urgent_ff <= 1'b1;
      offered_ff <= '0;
    end else if (offer_tick) begin
      offered_ff <= nxt_offered;
      if (all_offered) begin
        urgent_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // (R11) own term: station offset, next term adds one period of NS
  wire logic [STATION_W-1:0] slot_after_rx = own_station - rx_lead_station + STATION_W'(2);
  wire logic [STATION_W-1:0] slot_next_term = own_slot_ff + net_station_total;
  // a new header wins over a missed term, it restarts the term count
  wire logic term_missed = opportunity_tick && own_term && !tx_start;

  always_ff @(posedge clk) begin
    if (rst) begin
      own_slot_ff <= STATION_RESET;
    end else if (rx_end) begin
      own_slot_ff <= slot_after_rx;
    end else if (term_missed) begin
      own_slot_ff <= slot_next_term;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // (R15) voice variant steps the lead number by a fixed amount
  wire logic [STATION_W-1:0] lead_stepped = lead_ff + FIRST_STATION_STEP;
  // (R16) data variant increments the lead number
  wire logic [STATION_W-1:0] lead_incr = lead_ff + STATION_W'(1);
  wire logic [STATION_W-1:0] nxt_tx_lead = voice_data_mode ? lead_stepped : lead_incr;

  // (R8) transmit precedence follows the queue with one cycle lag
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_prec_ff <= PREC_ROUTINE;
      tx_lead_ff <= STATION_RESET;
      grant_ff <= 1'b0;
    end else begin
      tx_prec_ff <= queue_prec;
      tx_lead_ff <= nxt_tx_lead;
      grant_ff <= may_send;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign tx_grant = grant_ff;
  assign tx_link_precedence = tx_prec_ff;
  assign tx_lead_station = tx_lead_ff;
  assign urgent_mode = urgent_ff;
  assign startup_wait = (state_ff == ST_INIT);
endmodule : adaptive_priority_net_access

// ==== tb/access_props.sv ====
// concurrent checks on the access scheduler ports
`timescale 1ns/10ps
module access_props
  import access_pkg::*;
#(parameter logic [7:0] FIRST_STATION_STEP = 8'h01) (
  input wire logic clk, rst, voice_data_mode, urgent_queued, priority_queued, rx_end,
  input wire logic opportunity_tick, tx_grant, urgent_mode, startup_wait,
  input wire logic [1:0] rx_link_precedence, tx_link_precedence,
  input wire logic [7:0] net_station_total, rx_lead_station, tx_lead_station
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // saturating count of opportunities since a transmission ended
  logic [8:0] opp_ff;
  always_ff @(posedge clk) begin
    if (rst) opp_ff <= 9'h1FF;
    else if (rx_end) opp_ff <= 9'h000;
    else if (opportunity_tick && opp_ff != 9'h1FF) opp_ff <= opp_ff + 9'h001;
  end
  ////////////////////////////////////////////////////////////////
  a_startup_hold: assert property (startup_wait |-> !tx_grant)
    else $error("grant during start-up");
  a_reset_vals: assert property ($past(rst) |-> !tx_grant && !urgent_mode && startup_wait
    && tx_link_precedence == PREC_ROUTINE) else $error("bad reset values");
  a_prec_map: assert property (!$past(rst) |->
    tx_link_precedence == ($past(urgent_queued) ? PREC_URGENT :
    $past(priority_queued) ? PREC_PRIORITY : PREC_ROUTINE)) else $error("tx precedence wrong");
  a_lead_incr: assert property (rx_end && !voice_data_mode |-> ##2
    tx_lead_station == $past(rx_lead_station, 2) + 8'h01) else $error("lead not +1");
  a_lead_step: assert property (rx_end && voice_data_mode |-> ##2
    tx_lead_station == $past(rx_lead_station, 2) + FIRST_STATION_STEP) else $error("lead step");
  a_urgent_enter: assert property (rx_end && rx_link_precedence == PREC_URGENT
    |-> ##[1:2] urgent_mode) else $error("urgent mode not entered");
  // a grant reflects the count one cycle back; the reserved first slot is exempt
  a_nonurgent_wait: assert property (tx_grant && !$past(urgent_queued) &&
    $past(opp_ff) != 9'h000 |-> $past(opp_ff) > {1'h0, net_station_total})
    else $error("early non-urgent grant");
  a_routine_wait: assert property (tx_grant && !$past(urgent_queued) &&
    !$past(priority_queued) |-> $past(opp_ff) > {net_station_total, 1'h0})
    else $error("early routine");
endmodule : access_props
bind adaptive_priority_net_access access_props #(.FIRST_STATION_STEP(FIRST_STATION_STEP)) u_p (.*);

// ==== tb/net_peers.sv ====
// other stations on the net: transmission ends and opportunity ticks
`timescale 1ns/10ps
module net_peers (
  input wire logic clk,
  output logic rx_end = 1'h0,
  output logic [1:0] rx_link_precedence = 2'h3,
  output logic [7:0] rx_lead_station = 8'h00,
  output logic opportunity_tick = 1'h0
);
  // header valid only with the end pulse, scrambled after
  task automatic send(input logic [1:0] p, input logic [7:0] lead);
    @(posedge clk);
    rx_end <= 1'h1;
    rx_link_precedence <= p;
    rx_lead_station <= lead;
    @(posedge clk);
    rx_end <= 1'h0;
    rx_link_precedence <= ~p;
    rx_lead_station <= ~lead;
  endtask : send
  // peers hold off; one opportunity per two cycles
  task automatic tick;
    @(posedge clk);
    opportunity_tick <= 1'h1;
    @(posedge clk);
    opportunity_tick <= 1'h0;
  endtask : tick
endmodule : net_peers

// ==== tb/tb_adaptive_priority_net_access.sv ====
// self-checking bench for the access scheduler
`timescale 1ns/10ps
module tb_adaptive_priority_net_access;
  import access_pkg::*;
  logic clk = 1'h0, rst = 1'h1, voice_data_mode = 1'h0, link_up = 1'h0, tx_start = 1'h0;
  logic urgent_queued = 1'h0, priority_queued = 1'h0, routine_queued = 1'h0;
  logic [7:0] net_station_total = 8'h04, own_station = 8'h03;
  logic rx_end, opportunity_tick, tx_grant, urgent_mode, startup_wait;
  logic [1:0] rx_link_precedence, tx_link_precedence;
  logic [7:0] rx_lead_station, tx_lead_station;
  int fail_count = 0, checks_done = 0, k = 0, first = 0;
  initial forever #2 clk = ~clk;
  net_peers peer (.*);
  // unit delays keep the start-up wait short
  adaptive_priority_net_access #(.FIRST_STATION_STEP(8'h05), .TURNAROUND_BASE_CYC(1),
    .TURNAROUND_PER_DEST_CYC(1), .BUSY_SENSE_CYC(1), .TERMINAL_TURN_CYC(1)) uut (.*);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(startup_wait, 8'h01, "no start-up hold");
    link_up <= 1'h1;
    for (k = 0; k < 5000 && startup_wait !== 1'h0; k++) @(posedge clk);
    chk(k < 5000, 8'h01, "start-up never ends");
    $display("startup done");
    for (k = 0; k < 8; k++) begin
      {urgent_queued, priority_queued, routine_queued} <= 3'(k);
      repeat (2) @(posedge clk);
      #1 chk(tx_link_precedence, k[2] ? PREC_URGENT :
        k[1] ? PREC_PRIORITY : PREC_ROUTINE, "tx precedence");
      @(posedge clk);
    end
    $display("precedence done");
    peer.send(PREC_ROUTINE, 8'h07);
    repeat (2) @(posedge clk);
    #1 chk(tx_lead_station, 8'h08, "lead +1");
    voice_data_mode <= 1'h1;
    peer.send(PREC_ROUTINE, 8'h10);
    repeat (2) @(posedge clk);
    #1 chk(tx_lead_station, 8'h15, "lead step");
    voice_data_mode <= 1'h0;
    $display("lead done");
    {urgent_queued, priority_queued, routine_queued} <= 3'h0;
    peer.send(PREC_URGENT, 8'h02);
    repeat (3) peer.tick;
    #1 chk(urgent_mode, 8'h01, "urgent mode left early");
    repeat (4) peer.tick;
    #1 chk(urgent_mode, 8'h00, "urgent mode kept");
    $display("urgent done");
    routine_queued <= 1'h1;
    peer.send(PREC_ROUTINE, 8'h01);
    for (k = 1; k <= 20 && first == 0; k++) begin
      peer.tick;
      @(posedge clk);
      #1 if (tx_grant === 1'h1) first = k;
    end
    chk(first > 8, 8'h01, "routine grant early");
    chk(first != 0, 8'h01, "routine grant missing");
    $display("routine done");
    complete_run;
  end
endmodule : tb_adaptive_priority_net_access
